//--- anmon_defines.svh
// Offsets, field positions, reset values and codes of the progress monitor
// Included by the package and by the testbench
`ifndef ANMON_DEFINES_SVH
`define ANMON_DEFINES_SVH
`define ADR_DETAIL_STATUS   6'h00
`define ADR_IRQ_STATUS      6'h04
`define ADR_IRQ_MASK        6'h08
`define ADR_ARB_DEBUG       6'h0c
`define BIT_RATE            15
`define BIT_DUPLEX          14
`define BIT_PROG_HI         13
`define BIT_PROG_LO         11
`define BIT_COMPLETE        4
`define BIT_LINK            0
`define PROG_IDLE           4'h0
`define PROG_MAX_RUN        4'h8
`define PROG_DONE           4'hf
`define IRQ_PROGRESS        0
`define IRQ_COMPLETE        1
`define IRQ_LINK_FAIL       2
`define IRQ_WIDTH           3
`define IRQ_RESET           3'h0
`endif

//--- anmon_pkg.sv
// Types shared by the progress monitor files
// Assumes the defines header sits in the include path
package anmon_pkg;
`include "anmon_defines.svh"
   typedef logic [3:0] prog_code_t;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_t;
endpackage : anmon_pkg

//--- autoneg_progress_monitor.sv
// Auto-negotiation progress monitor with detailed status and interrupt registers
// Function
// R1: Progress code is complete flag then status bits 13, 12, 11.
// R2: Progress code only takes values zero to eight and fifteen.
// R3: Arbitration state loads automatically only when greater than held code.
// R4: Every management read loads current arbitration state unconditionally.
// R5: Read returns the code held before the read, not the new capture.
// R6: Management reads twice: first gives history, second gives present state.
// R7: After completion all four bits are one; first read shows 1 and 111.
// R8: Later reads show complete one and low bits 000 while link holds.
// R9: Link failure restarts negotiation; reads follow arbitration state again.
// R10: Detail status carries rate bit 15, duplex 14, link 0, complete 4.
// R11: Management polls standard complete and link bits for link up.
// R12: Management expects completion under about 500 ms, then diagnoses.
// R13: Any reset returns monitor to idle and clears all progress bits.
// R14: Restart keeps held code; only read, reset or progress changes it.
// R15: After completion only a read or reset alters progress bits.
// R16: Compare as four-bit unsigned and update within one clock.
// Assumes arbitration, rate, duplex and link come from other clock domains
// and are synchronised here; classic Wishbone slave on sys_clk.
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
module autoneg_progress_monitor
   import anmon_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   input  wire anmon_pkg::prog_code_t arb_state,
   input  wire logic             link_up,
   input  wire logic             rate_100,
   input  wire logic             full_duplex,
   input  wire logic             an_restart,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [5:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   output logic                  irq,
   output logic                  restart_req
);
   import anmon_pkg::*;

   logic [6:0]  pins_s;
   prog_code_t  arb_s;
   logic        link_s;
   logic        rate_s;
   logic        dup_s;
   logic        restart_s;

   sync2 #(.W(7)) u_sync (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .clk_en  (clk_en),
      .d       ({arb_state, link_up, rate_100, full_duplex}),
      .q       (pins_s)
   );

   assign arb_s  = pins_s[6:3];
   assign link_s = pins_s[2];
   assign rate_s = pins_s[1];
   assign dup_s  = pins_s[0];
   assign restart_s = an_restart;

   // Register state
   prog_code_t                 prog_r;
   prog_code_t                 prog_nxt;
   logic                       done_seen_r;
   logic                       link_d_r;
   logic [`IRQ_WIDTH-1:0]      irq_stat_r;
   logic [`IRQ_WIDTH-1:0]      irq_stat_nxt;
   logic [`IRQ_WIDTH-1:0]      irq_mask_r;
   bus_state_t                 bus_r;
   logic [31:0]                rdata_nxt;

   // Out-of-range states are treated as idle so the code never leaves its set
   logic       arb_legal;
   prog_code_t arb_q;
   assign arb_legal = (arb_s <= `PROG_MAX_RUN) || (arb_s == `PROG_DONE); // R2
   assign arb_q     = arb_legal ? arb_s : `PROG_IDLE; // R2

   // Bus decode
   logic req;
   logic rd_strobe;
   logic wr_strobe;
   logic hit_detail;
   logic hit_istat;
   logic hit_imask;
   logic hit_dbg;
   assign req        = wb_cyc_i && wb_stb_i && (bus_r == BUS_IDLE);
   assign rd_strobe  = req && !wb_we_i;
   assign wr_strobe  = req && wb_we_i && wb_sel_i[0];
   assign hit_detail = (wb_adr_i == `ADR_DETAIL_STATUS);
   assign hit_istat  = (wb_adr_i == `ADR_IRQ_STATUS);
   assign hit_imask  = (wb_adr_i == `ADR_IRQ_MASK);
   assign hit_dbg    = (wb_adr_i == `ADR_ARB_DEBUG);

   logic detail_rd;
   assign detail_rd = rd_strobe && hit_detail;

   // Once a completed code has been read out, low bits read zero until link drops or a restart arrives
   logic [2:0] low_view;
   assign low_view = done_seen_r ? 3'h0 : prog_r[2:0]; // R8

   logic link_fail;
   assign link_fail = link_d_r && !link_s; // R9

   // Held code update: a read captures unconditionally, otherwise only upward
   logic upward;
   assign upward = (arb_q > prog_r); // R16 R3
   always_comb begin
      prog_nxt = prog_r;
      if (detail_rd) begin
         prog_nxt = arb_q; // R4
      end else if (upward && !done_seen_r) begin
         prog_nxt = arb_q; // R3 R15
      end
      // Restart leaves the held code alone on purpose
      if (restart_s) begin
         prog_nxt = prog_nxt; // R14
      end
   end

   logic [`IRQ_WIDTH-1:0] irq_evt;
   assign irq_evt[`IRQ_PROGRESS]  = (prog_nxt != prog_r);
   assign irq_evt[`IRQ_COMPLETE]  = (arb_q == `PROG_DONE) && (prog_r != `PROG_DONE) && !done_seen_r;
   assign irq_evt[`IRQ_LINK_FAIL] = link_fail;

   logic [`IRQ_WIDTH-1:0] irq_clr;
   assign irq_clr = (wr_strobe && hit_istat) ? wb_dat_i[`IRQ_WIDTH-1:0] : '0;
   // Set wins over a clear arriving in the same cycle
   assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;

   // Read data: code as held before this read
   logic [15:0] detail_word;
   always_comb begin
      detail_word = 16'h0000;
      detail_word[`BIT_RATE]    = rate_s; // R10
      detail_word[`BIT_DUPLEX]  = dup_s; // R10
      detail_word[`BIT_PROG_HI:`BIT_PROG_LO] = low_view; // R1 R5 R7
      detail_word[`BIT_COMPLETE] = prog_r[3]; // R1 R7
      detail_word[`BIT_LINK]    = link_s; // R10
   end

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hit_detail) begin
         rdata_nxt = {16'h0000, detail_word};
      end else if (hit_istat) begin
         rdata_nxt = {29'h0, irq_stat_r};
      end else if (hit_imask) begin
         rdata_nxt = {29'h0, irq_mask_r};
      end else if (hit_dbg) begin
         rdata_nxt = {28'h0, arb_q};
      end
   end

   // Any reset clears the monitor to idle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prog_r <= `PROG_IDLE; // R13
      end else if (clk_en) begin
         prog_r <= prog_nxt;
      end
   end

   // First read of a completed code arms the zero view of the low bits
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         done_seen_r <= 1'b0; // R13
      end else if (clk_en) begin
         if (link_fail || restart_s) begin
            done_seen_r <= 1'b0; // R9
         end else if (detail_rd && (prog_r == `PROG_DONE)) begin
            done_seen_r <= 1'b1; // R7 R8
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         link_d_r    <= 1'b0;
         restart_req <= 1'b0;
      end else if (clk_en) begin
         link_d_r    <= link_s;
         restart_req <= link_fail; // R9
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_r <= `IRQ_RESET;
         irq_mask_r <= `IRQ_RESET;
         irq        <= 1'b0;
      end else if (clk_en) begin
         irq_stat_r <= irq_stat_nxt;
         if (wr_strobe && hit_imask) begin
            irq_mask_r <= wb_dat_i[`IRQ_WIDTH-1:0];
         end
         irq <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   // Single-wait-state slave: ack one cycle after the request, then one idle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_r    <= BUS_IDLE;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (clk_en) begin
         unique case (bus_r)
            BUS_IDLE: begin
               wb_ack_o <= req;
               if (req) begin
                  bus_r    <= BUS_ACK;
                  wb_dat_o <= rdata_nxt;
               end
            end
            BUS_ACK: begin
               wb_ack_o <= 1'b0;
               bus_r    <= BUS_IDLE;
            end
         endcase
      end
   end
endmodule : autoneg_progress_monitor

//--- autoneg_progress_monitor_checker.sv
// Port-level assertions for the progress monitor
// Assumes one sys_clk domain and the async active-low rst_b
`timescale 1ns/10ps
module progress_checker (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        clk_en,
   input wire logic        link_up,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [5:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        restart_req
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
   wire rd   = wb_cyc_i && wb_stb_i && !wb_we_i;
   wire [3:0] code = {wb_dat_o[4], wb_dat_o[13:11]};
   chk_ack_after_take:
      assert property (take |=> wb_ack_o) else $error("request not acked");
   chk_ack_one_cycle:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   chk_ack_needs_req:
      assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
   chk_data_holds:
      assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("read data moved");
   chk_unmapped_zero:
      assert property (wb_ack_o && $past(rd && wb_adr_i > 6'h0c) |-> wb_dat_o == 32'h0)
         else $error("unmapped read not zero");
   chk_code_legal:
      assert property (wb_ack_o && $past(rd && wb_adr_i == 6'h00) |->
         (code <= 4'h8 || code == 4'hf)) else $error("illegal progress code");
   chk_restart_pulse:
      assert property (restart_req |=> !restart_req) else $error("restart not a pulse");
   chk_restart_cause:
      assert property (restart_req |-> !$past(link_up, 3) && $past(link_up, 4))
         else $error("restart without link loss");
endmodule : progress_checker
bind autoneg_progress_monitor progress_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
   .clk_en(clk_en), .link_up(link_up), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .restart_req(restart_req));

//--- sta_master.sv
// Station management model: classic Wishbone master, single transfers
// Assumes the slave acks every request; the bench timeout bounds a hang
`timescale 1ns/10ps
module sta_master (
   input  wire logic        sys_clk,
   input  wire logic        wb_ack_o,
   input  wire logic [31:0] wb_dat_o,
   output logic             cyc,
   output logic             we,
   output logic [5:0]       adr,
   output logic [31:0]      dat
);
   initial begin
      cyc = 1'b0;
      we = 1'b0;
      adr = 6'h00;
      dat = 32'h0;
   end
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge sys_clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      dat <= ~d;
   endtask : xfer
   // First read gives the history, second the present state
   task automatic poll2(output logic [31:0] h, output logic [31:0] p);
      xfer(1'b0, 6'h00, 32'h0, h);
      xfer(1'b0, 6'h00, 32'h0, p);
   endtask : poll2
endmodule : sta_master

//--- sync2.sv
// Two-stage synchroniser for a bundle of pin levels
// Assumes inputs are quasi-static levels from outside sys_clk
`timescale 1ns/10ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_b,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         q      <= '0;
      end else if (clk_en) begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : sync2

//--- tb_autoneg_progress_monitor.sv
// Self-checking bench: random arbitration walks, completion, link loss, irq
// Assumes the design package and defines header are on the include path
`timescale 1ns/10ps
`include "anmon_defines.svh"
module tb_autoneg_progress_monitor;
   import anmon_pkg::*;
   logic        sys_clk, rst_b, link_up, rate_100, full_duplex, an_restart;
   logic        cyc, we, ack, irq, restart_req, seen;
   logic [5:0]  adr;
   logic [31:0] dat, dat_o, q, h, p, seed;
   prog_code_t  arb_state, a, held;
   int          error_cnt, samples_checked, cycles;
   autoneg_progress_monitor dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
      .arb_state(arb_state), .link_up(link_up), .rate_100(rate_100),
      .full_duplex(full_duplex), .an_restart(an_restart), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .irq(irq), .restart_req(restart_req));
   sta_master u_sta (.sys_clk(sys_clk), .wb_ack_o(ack), .wb_dat_o(dat_o), .cyc(cyc),
      .we(we), .adr(adr), .dat(dat));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function automatic logic [31:0] det(input prog_code_t c);
      return {16'h0, rate_100, full_duplex, c[2:0], 6'h0, c[3], 3'h0, link_up};
   endfunction : det
   task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
      samples_checked++;
      if (seen_v !== exp_v) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask : check
   task automatic conclude;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // Two synchroniser flops plus margin
   task automatic settle;
      repeat (5) @(posedge sys_clk);
   endtask : settle
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      {rst_b, rate_100, full_duplex, an_restart, arb_state, held} = '0;
      link_up = 1'b1;
      seed = 32'h54;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      settle();
      u_sta.xfer(1'b0, `ADR_DETAIL_STATUS, 32'h0, q);
      check(q, det(4'h0));
      for (int i = 0; i < 24; i++) begin
         seed = xs(seed);
         a = prog_code_t'(seed % 9);
         arb_state <= a;
         {rate_100, full_duplex, an_restart} <= seed[11:9];
         @(posedge sys_clk);
         an_restart <= 1'b0;
         settle();
         if (a > held) held = a;
         u_sta.poll2(h, p);
         check(h, det(held));
         check(p, det(a));
         held = a;
      end
      u_sta.xfer(1'b1, 6'h10, 32'hffff, q);
      u_sta.xfer(1'b0, 6'h10, 32'h0, q);
      check(q, 32'h0);
      arb_state <= `PROG_DONE;
      settle();
      u_sta.poll2(h, p);
      check(h, det(4'hf));
      check(p, det(4'h8));
      arb_state <= 4'h2;
      settle();
      u_sta.xfer(1'b0, `ADR_DETAIL_STATUS, 32'h0, q);
      check(q, det(4'h8));
      check(irq, 1'b0);
      arb_state <= 4'h4;
      link_up <= 1'b0;
      seen = 1'b0;
      for (int k = 0; k < 8; k++) begin
         @(posedge sys_clk);
         if (restart_req === 1'b1) seen = 1'b1;
      end
      check(seen, 1'b1);
      u_sta.xfer(1'b1, `ADR_IRQ_MASK, 32'h4, q);
      repeat (2) @(posedge sys_clk);
      check(irq, 1'b1);
      u_sta.xfer(1'b0, `ADR_IRQ_STATUS, 32'h0, q);
      check(q & 32'h4, 32'h4);
      u_sta.xfer(1'b1, `ADR_IRQ_STATUS, 32'h4, q);
      u_sta.xfer(1'b0, `ADR_IRQ_STATUS, 32'h0, q);
      check(q & 32'h4, 32'h0);
      check(irq, 1'b0);
      u_sta.poll2(h, p);
      check(p, det(4'h4));
      u_sta.xfer(1'b0, `ADR_ARB_DEBUG, 32'h0, q);
      check(q, 32'h4);
      conclude();
   end
endmodule : tb_autoneg_progress_monitor
